/* src/pirc_consts.svh */
// Purpose: constants for the phy interrupt, reset and power-down block
// Assumes: 250 MHz device clock
// Notes:   register indices are management register numbers
`ifndef PIRC_CONSTS_SVH
`define PIRC_CONSTS_SVH
`define PIRC_REG_CTRL      5'h00
`define PIRC_REG_STAT      5'h01
`define PIRC_REG_ANEXP     5'h06
`define PIRC_REG_IDLECNT   5'h0a
`define PIRC_REG_FLAGS     5'h1d
`define PIRC_REG_MASK      5'h1e
`define PIRC_BIT_SRST      15
`define PIRC_BIT_PDOWN     11
`define PIRC_SRC_MASK      16'h07f7
`define PIRC_ZERO16        16'h0000
`define PIRC_CLK_MHZ       250
`define PIRC_T_RST_US      256
`define PIRC_T_ENERGY_MS   256
`define PIRC_RST_CYC       (`PIRC_T_RST_US * `PIRC_CLK_MHZ)
`define PIRC_ENERGY_CYC    (`PIRC_T_ENERGY_MS * 1000 * `PIRC_CLK_MHZ)
`define PIRC_CNT_W         27
`endif

/* src/pirc_pkg.sv */
// Purpose: types for the phy interrupt, reset and power-down block
// Assumes: nothing
// Notes:   none
package pirc_pkg;
   typedef struct packed {
      logic tx_ovf;
      logic tx_unf;
      logic idle_ovf;
      logic energy;
      logic an_done;
      logic rem_fault;
      logic link_up;
      logic par_fault;
      logic page_rx;
      logic renego;
   } pirc_src_t;
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } pirc_mgmt_t;
   typedef enum logic [1:0] {
      PIRC_RUN, PIRC_PD, PIRC_PDRST, PIRC_SRST
   } pirc_state_t;
endpackage

/* src/pirc_top.sv */
// Purpose: interrupt flags and mask, reset and power-down control
// Assumes: management accesses arrive decoded as one-cycle strobes
// Notes:   energy timers are top-level parameters for short simulation
//
// Functional notes
// - interrupt pin low while any enabled flag is set, high otherwise.
// - every enable bit is zero after hardware or soft reset.
// - mask register 30 bits 10:0 match flag register 29; 15:11,3 reserved.
// - flags 10 and 9 follow transmit buffer overflow and underflow.
// - flag 8 sets on idle overflow level; flags 7..1 rise on listed source edges.
// - flags clear on listed reads, falling sources, renegotiation, link loss.
// - energy bit reads one after hardware reset, clears after 256 ms quiet.
// - energy rise and loss raise flag 7; bit clears 256 ms after loss.
// - energy-loss flag fires 256 ms after link break or return to detect.
// - hardware reset clears registers and relatches straps on release.
// - soft reset bit resets logic, self-clears after 256 us.
// - soft reset clears mask register, keeps flags; straps not relatched.
// - leaving power-down holds internal reset 256 us, registers kept.
// - power-down bit powers down all but management; clear applies reset.
// - energy-detect power-down with no energy powers down, transmits nothing.
// - energy returning sets energy bit, powers up, may raise request.
// - power-down pin powers down all but management; strap picks pll.
// - power-down pin held during hardware reset wakes in power-down.
// - strap low disables pll in pin power-down, high keeps it.
`timescale 1ns/10ps
`include "pirc_consts.svh"
module pirc_top #(
   parameter int unsigned ENERGY_CYC = `PIRC_ENERGY_CYC
) (
   // clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   // pins
   input  wire logic                i_hw_reset_n_pin,
   input  wire logic                i_hw_powerdown_pin,
   input  wire logic                i_hw_pd_pll_select_strap,
   // datapath status
   input  wire pirc_pkg::pirc_src_t i_src,
   input  wire logic                i_energy_raw,
   input  wire logic                i_energy_detect_pd_enable,
   // management
   input  wire pirc_pkg::pirc_mgmt_t i_mgmt,
   output logic [15:0]              o_rdata,
   // outputs
   output logic                     o_irq_n,
   output logic                     o_line_energy_present,
   output logic                     o_logic_rst,
   output logic                     o_powered_down,
   output logic                     o_pll_off,
   output logic                     o_tx_off
);
   import pirc_pkg::*;

   // ***************************************************************
   // access decode
   // ***************************************************************
   function automatic logic hit(input pirc_mgmt_t m, input logic [4:0] a);
      hit = m.rd && (m.addr == a);
   endfunction

   wire logic hard_rst = i_rst || !i_hw_reset_n_pin;
   wire logic rd_flags = hit(i_mgmt, `PIRC_REG_FLAGS);
   wire logic rd_stat  = hit(i_mgmt, `PIRC_REG_STAT);
   wire logic rd_anexp = hit(i_mgmt, `PIRC_REG_ANEXP);
   wire logic rd_idle  = hit(i_mgmt, `PIRC_REG_IDLECNT);
   wire logic wr_mask  = i_mgmt.wr && (i_mgmt.addr == `PIRC_REG_MASK);
   wire logic wr_ctrl  = i_mgmt.wr && (i_mgmt.addr == `PIRC_REG_CTRL);

   // ***************************************************************
   // state and registers
   // ***************************************************************
   pirc_src_t   prev_q;
   logic        energy_q;
   logic [15:0] flags_q, flags_d, mask_q;
   logic        pdown_q, srst_q, strap_q, pin_pd_q, edpd_q;
   logic [`PIRC_CNT_W-1:0] ecnt_q, rcnt_q;
   logic        eloss_q, rel_q;
   pirc_state_t st_q, st_d;

   wire logic en_rise = !energy_q && i_energy_raw;
   wire logic en_fall = energy_q && !i_energy_raw;
   wire logic e_timeout = eloss_q && (ecnt_q == '0);

   wire logic irq_any = |(flags_q & mask_q & `PIRC_SRC_MASK);

   // ***************************************************************
   // interrupt source flags
   // ***************************************************************
   wire logic [15:0] set_v = {5'h00,
      i_src.tx_ovf, i_src.tx_unf, i_src.idle_ovf,
      en_rise || e_timeout,
      i_src.an_done && !prev_q.an_done,
      i_src.rem_fault && !prev_q.rem_fault,
      !i_src.link_up && prev_q.link_up, 1'b0,
      i_src.par_fault && !prev_q.par_fault,
      i_src.page_rx && !prev_q.page_rx, 1'b0};
   // link loss is the falling edge, not the down level
   wire logic an_clr = rd_anexp || rd_flags || i_src.renego ||
                       (!i_src.link_up && prev_q.link_up);
   wire logic [15:0] clr_v = {5'h00,
      !i_src.tx_ovf, !i_src.tx_unf, rd_idle,
      rd_flags || (energy_q && !i_energy_raw && !eloss_q),
      rd_flags || !i_src.an_done,
      rd_flags || rd_stat || !i_src.rem_fault,
      rd_flags || rd_stat, 1'b0,
      an_clr || !i_src.par_fault,
      an_clr || !i_src.page_rx, 1'b0};

   // tx flags follow level; edge set wins over clear
   always_comb begin
      flags_d = ((flags_q & ~clr_v) | set_v) & `PIRC_SRC_MASK;
   end

   always_ff @(posedge i_clk) begin
      if (hard_rst) begin
         flags_q <= `PIRC_ZERO16;
         prev_q  <= '0;
      end else begin
         flags_q <= flags_d;
         prev_q  <= i_src;
      end
   end

   // ***************************************************************
   // mask register
   // ***************************************************************
   // cleared by hardware and soft reset, reserved bits held zero
   always_ff @(posedge i_clk) begin
      if (hard_rst || srst_q) begin
         mask_q <= `PIRC_ZERO16;
      end else if (wr_mask) begin
         mask_q <= i_mgmt.wdata & `PIRC_SRC_MASK;
      end
   end

   // ***************************************************************
   // line energy
   // ***************************************************************
   // energy bit set on rise, 256 ms hold after loss
   always_ff @(posedge i_clk) begin
      if (hard_rst) begin
         energy_q <= 1'b1;
         eloss_q  <= 1'b1;
         ecnt_q   <= ENERGY_CYC[`PIRC_CNT_W-1:0];
      end else if (i_energy_raw) begin
         energy_q <= 1'b1;
         eloss_q  <= 1'b0;
         ecnt_q   <= ENERGY_CYC[`PIRC_CNT_W-1:0];
      end else if (en_fall && !eloss_q) begin
         eloss_q  <= 1'b1;
      end else if (e_timeout) begin
         energy_q <= 1'b0;
         eloss_q  <= 1'b0;
      end else if (eloss_q) begin
         ecnt_q   <= ecnt_q - 1'b1;
      end
   end

   // ***************************************************************
   // control bits and straps
   // ***************************************************************
   // strap caught in the cycle after release, pin sampled every cycle
   always_ff @(posedge i_clk) begin
      if (hard_rst) begin
         rel_q    <= 1'b1;
         strap_q  <= 1'b0;
         pin_pd_q <= 1'b0;
      end else begin
         rel_q    <= 1'b0;
         pin_pd_q <= i_hw_powerdown_pin;
         if (rel_q) begin
            strap_q <= i_hw_pd_pll_select_strap;
         end
      end
   end

   // soft reset keeps power-down and strap state
   always_ff @(posedge i_clk) begin
      if (hard_rst) begin
         pdown_q <= 1'b0;
         srst_q  <= 1'b0;
         edpd_q  <= 1'b0;
      end else begin
         edpd_q <= i_energy_detect_pd_enable;
         if (wr_ctrl) begin
            pdown_q <= i_mgmt.wdata[`PIRC_BIT_PDOWN];
            srst_q  <= i_mgmt.wdata[`PIRC_BIT_SRST];
         end else if (st_q == PIRC_SRST && rcnt_q == '0) begin
            srst_q  <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // power and reset sequencer
   // ***************************************************************
   wire logic pd_req = pdown_q || pin_pd_q ||
                       (edpd_q && !energy_q);
   always_comb begin
      st_d = st_q;
      case (st_q)
         PIRC_RUN: begin
            if (pd_req) st_d = PIRC_PD;
            else if (srst_q) st_d = PIRC_SRST;
         end
         PIRC_PD: begin
            if (!pd_req) st_d = PIRC_PDRST;
         end
         PIRC_PDRST: begin
            if (rcnt_q == '0) st_d = PIRC_RUN;
         end
         PIRC_SRST: begin
            if (rcnt_q == '0) st_d = PIRC_RUN;
         end
         default: st_d = PIRC_RUN;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (hard_rst) begin
         st_q   <= PIRC_RUN;
         rcnt_q <= '0;
      end else begin
         st_q <= st_d;
         if (st_d != st_q) begin
            rcnt_q <= `PIRC_CNT_W'(`PIRC_RST_CYC - 1);
         end else if (rcnt_q != '0) begin
            rcnt_q <= rcnt_q - 1'b1;
         end
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   always_ff @(posedge i_clk) begin
      if (hard_rst) begin
         o_irq_n               <= 1'b1;
         o_line_energy_present <= 1'b1;
         o_logic_rst           <= 1'b1;
         o_powered_down        <= 1'b0;
         o_pll_off             <= 1'b0;
         o_tx_off              <= 1'b0;
         o_rdata               <= `PIRC_ZERO16;
      end else begin
         o_irq_n               <= !irq_any;
         o_line_energy_present <= energy_q;
         o_logic_rst           <= (st_q == PIRC_PDRST) ||
                                  (st_q == PIRC_SRST);
         o_powered_down        <= (st_q == PIRC_PD);
         // pll off only when strap low in pin power-down
         o_pll_off             <= (st_q == PIRC_PD) && pin_pd_q &&
                                  !strap_q;
         o_tx_off              <= (st_q != PIRC_RUN);
         o_rdata               <= rd_flags ? flags_q :
                                  hit(i_mgmt, `PIRC_REG_MASK) ? mask_q :
                                  `PIRC_ZERO16;
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   property p_irq_follows;
      @(posedge i_clk) disable iff (hard_rst)
         irq_any |=> !o_irq_n;
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("request not asserted");
   property p_mask_reset;
      @(posedge i_clk) $fell(hard_rst) |-> mask_q == `PIRC_ZERO16;
   endproperty
   a_mask_reset: assert property (p_mask_reset)
      else $error("mask not zero after reset");
   property p_reserved;
      @(posedge i_clk) disable iff (hard_rst)
         (flags_q[15:11] == 5'h00) && !flags_q[3] && !mask_q[3];
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bit set");
   property p_txovf;
      @(posedge i_clk) disable iff (hard_rst)
         i_src.tx_ovf |=> flags_q[10];
   endproperty
   a_txovf: assert property (p_txovf)
      else $error("overflow flag missing");
   property p_linkdown;
      @(posedge i_clk) disable iff (hard_rst)
         $fell(i_src.link_up) |=> flags_q[4];
   endproperty
   a_linkdown: assert property (p_linkdown)
      else $error("link down flag missing");
   property p_idle_clr;
      @(posedge i_clk) disable iff (hard_rst)
         rd_idle && !i_src.idle_ovf |=> !flags_q[8];
   endproperty
   a_idle_clr: assert property (p_idle_clr)
      else $error("idle flag not cleared");
   property p_energy_rise;
      @(posedge i_clk) disable iff (hard_rst)
         en_rise |=> energy_q && flags_q[7];
   endproperty
   a_energy_rise: assert property (p_energy_rise)
      else $error("energy rise not flagged");
   property p_pd_outputs;
      @(posedge i_clk) disable iff (hard_rst)
         st_q == PIRC_PD |=> o_powered_down && o_tx_off;
   endproperty
   a_pd_outputs: assert property (p_pd_outputs)
      else $error("power-down not shown");
   property p_pdrst;
      @(posedge i_clk) disable iff (hard_rst)
         st_q == PIRC_PD && !pd_req |=> st_q == PIRC_PDRST;
   endproperty
   a_pdrst: assert property (p_pdrst)
      else $error("no power-down reset");
   property p_irq_quiet;
      @(posedge i_clk) disable iff (hard_rst)
         ((flags_q & mask_q) == `PIRC_ZERO16) |=> o_irq_n;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("request without enabled flag");
   property p_srst_clear;
      @(posedge i_clk) disable iff (hard_rst)
         (st_q == PIRC_SRST) && (rcnt_q == '0) && !wr_ctrl |=> !srst_q;
   endproperty
   a_srst_clear: assert property (p_srst_clear)
      else $error("soft reset bit not self-cleared");
   property p_pll_kept;
      @(posedge i_clk) disable iff (hard_rst)
         strap_q |=> !o_pll_off;
   endproperty
   a_pll_kept: assert property (p_pll_kept)
      else $error("pll off with strap high");
   c_irq: cover property (@(posedge i_clk) $fell(o_irq_n));
   c_pd: cover property (@(posedge i_clk) st_q == PIRC_PDRST);
   c_srst: cover property (@(posedge i_clk) $fell(srst_q));
endmodule

/* tb/pirc_mgmt_model.sv */
// Purpose: management controller model issuing register strobes
// Assumes: one strobe cycle per access, read data one cycle later
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/10ps
module pirc_mgmt_model (
   // clock
   input  wire logic            i_clk,
   // management
   output pirc_pkg::pirc_mgmt_t o_mgmt,
   input  wire logic [15:0]     i_rdata
);
   import pirc_pkg::*;
   // ************************************************
   // access tasks
   // ************************************************
   initial o_mgmt = '{1'b0, 1'b0, 5'h1f, 16'h0000};
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge i_clk);
      #1 o_mgmt = '{1'b0, 1'b1, a, v};
      @(posedge i_clk);
      #1 o_mgmt = '{1'b0, 1'b0, ~a, ~v};
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      @(posedge i_clk);
      #1 o_mgmt = '{1'b1, 1'b0, a, ~o_mgmt.wdata};
      @(posedge i_clk);
      #1 o_mgmt = '{1'b0, 1'b0, ~a, ~o_mgmt.wdata};
      v = i_rdata;
   endtask
   task automatic svc(output logic [15:0] v);
      rd(5'h1d, v);
      wr(5'h1e, 16'h0000);
   endtask
endmodule

/* tb/pirc_top_bench.sv */
// Purpose: self-checking bench for interrupt, reset and power-down block
// Assumes: energy hold shortened to ECYC cycles
// Notes:   registers reached through the management model
`timescale 1ns/10ps
module pirc_top_bench;
   import pirc_pkg::*;
   localparam int unsigned ECYC = 50;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        rst_n_pin = 1'b1;
   logic        pd_pin = 1'b0;
   logic        strap = 1'b0;
   logic        eraw = 1'b0;
   logic        edpd = 1'b0;
   pirc_src_t   src = '0;
   pirc_mgmt_t  mgmt;
   logic [15:0] rdata;
   logic [15:0] q;
   logic [15:0] d;
   logic        irq_n;
   logic        energy;
   logic        lrst;
   logic        pdn;
   logic        plloff;
   logic        txoff;
   int          bad_count = 0;
   int          check_count = 0;
   int          n;
   int unsigned sidx [6] = '{5, 4, 3, 2, 7, 1};
   int unsigned flg  [6] = '{6, 5, 4, 2, 8, 1};
   logic [4:0]  clr  [6] = '{5'h1d, 5'h01, 5'h01, 5'h06, 5'h0a, 5'h00};
   pirc_top #(.ENERGY_CYC(ECYC)) dut (
      .i_clk                     (clk),
      .i_rst                     (rst),
      .i_hw_reset_n_pin          (rst_n_pin),
      .i_hw_powerdown_pin        (pd_pin),
      .i_hw_pd_pll_select_strap  (strap),
      .i_src                     (src),
      .i_energy_raw              (eraw),
      .i_energy_detect_pd_enable (edpd),
      .i_mgmt                    (mgmt),
      .o_rdata                   (rdata),
      .o_irq_n                   (irq_n),
      .o_line_energy_present     (energy),
      .o_logic_rst               (lrst),
      .o_powered_down            (pdn),
      .o_pll_off                 (plloff),
      .o_tx_off                  (txoff)
   );
   pirc_mgmt_model m (
      .i_clk   (clk),
      .o_mgmt  (mgmt),
      .i_rdata (rdata)
   );
   // ************************************************
   // helpers
   // ************************************************
   always #2 clk = ~clk;
   function automatic logic [15:0] exp_mask(input logic [15:0] v);
      return v & `PIRC_SRC_MASK;
   endfunction
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic pin_reset(input logic st, input logic pd);
      strap = st;
      pd_pin = pd;
      rst_n_pin = 1'b0;
      tick(5);
      rst_n_pin = 1'b1;
      tick(2);
   endtask
   initial begin
      #360000;
      bad_count++;
      stop_test();
   end
   // ************************************************
   // tests
   // ************************************************
   initial begin
      void'($urandom(32'hf541_8f5c));
      tick(5);
      rst = 1'b0;
      tick(2);
      m.wr(5'h00, 16'h4040);
      pin_reset(1'b0, 1'b0);
      check(irq_n, 1'b1);
      check(energy, 1'b1);
      tick(ECYC + 10);
      check(energy, 1'b0);
      m.rd(5'h1e, q);
      check(q, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         d = (i == 0) ? 16'hffff : 16'($urandom);
         m.wr(5'h1e, d);
         m.wr(5'h0b, ~d);
         m.rd(5'h1e, q);
         check(q, exp_mask(d));
      end
      m.wr(5'h1e, 16'h0400);
      for (int i = 0; i < 2; i++) begin
         src[9 - i] = 1'b1;
         tick(4);
         check(irq_n, i[0]);
         m.rd(5'h1d, q);
         check(q & 16'h0600, 16'h0400 >> i);
         src[9 - i] = 1'b0;
         tick(4);
         check(irq_n, 1'b1);
      end
      m.wr(5'h1e, 16'h0777);
      for (int i = 0; i < 6; i++) begin
         src[sidx[i]] = (sidx[i] == 3);
         tick(4);
         m.rd(5'h1d, q);
         src[sidx[i]] = (sidx[i] != 3);
         tick(4);
         if (sidx[i] == 7)
            src[7] = 1'b0;
         tick(2);
         check(irq_n, 1'b0);
         if (clr[i] == 5'h00) begin
            src.renego = 1'b1;
            tick(1);
            src.renego = 1'b0;
         end else
            m.rd(clr[i], q);
         if (clr[i] == 5'h1d)
            check(q & 16'h0777, 16'h0001 << flg[i]);
         tick(4);
         check(irq_n, 1'b1);
         src[sidx[i]] = 1'b0;
      end
      m.wr(5'h1e, 16'h0080);
      eraw = 1'b1;
      tick(4);
      check(energy, 1'b1);
      check(irq_n, 1'b0);
      m.svc(q);
      tick(3);
      check(irq_n, 1'b1);
      m.wr(5'h1e, 16'h0080);
      eraw = 1'b0;
      tick(ECYC - 10);
      check(irq_n, 1'b1);
      tick(20);
      check(irq_n, 1'b0);
      check(energy, 1'b0);
      m.svc(q);
      edpd = 1'b1;
      tick(4);
      check(txoff, 1'b1);
      check(pdn, 1'b1);
      m.wr(5'h1e, 16'h0080);
      eraw = 1'b1;
      tick(4);
      check(pdn, 1'b0);
      check(txoff, 1'b1);
      check(lrst, 1'b1);
      check(energy, 1'b1);
      check(irq_n, 1'b0);
      m.svc(q);
      edpd = 1'b0;
      pin_reset(1'b0, 1'b0);
      m.wr(5'h1e, 16'h0123);
      m.wr(5'h00, 16'h0800);
      tick(4);
      check(pdn, 1'b1);
      m.wr(5'h00, 16'h0000);
      tick(4);
      check(lrst, 1'b1);
      m.rd(5'h1e, q);
      check(q, 16'h0123);
      pin_reset(1'b0, 1'b0);
      m.rd(5'h1e, q);
      check(q, 16'h0000);
      strap = 1'b1;
      m.wr(5'h1e, 16'h0010);
      m.wr(5'h00, 16'h8000);
      n = 0;
      while (lrst !== 1'b1 && n < 10) begin
         tick(1);
         n++;
      end
      n = 0;
      while (lrst === 1'b1 && n < 70000) begin
         tick(1);
         n++;
      end
      check(n >= 63996 && n <= 64004, 1'b1);
      m.rd(5'h1e, q);
      check(q, 16'h0000);
      pd_pin = 1'b1;
      tick(4);
      check(pdn, 1'b1);
      check(plloff, 1'b1);
      pd_pin = 1'b0;
      m.wr(5'h00, 16'h0000);
      pin_reset(1'b1, 1'b1);
      tick(1);
      check(pdn, 1'b1);
      check(plloff, 1'b0);
      stop_test();
   end
endmodule
